// ---- hdl/lcdhif_defines.svh ----
// Offsets, field positions, reset values and timing counts for the LCD host port.
// Assumes a 10 MHz system clock.
`ifndef LCDHIF_DEFINES_SVH
`define LCDHIF_DEFINES_SVH

`define LCDHIF_CLK_MHZ 10
`define LCDHIF_RESET_MIN_US 10
`define LCDHIF_RESET_CYCLES (`LCDHIF_RESET_MIN_US * `LCDHIF_CLK_MHZ)

`define LCDHIF_REG_BANK_SEL 4'hf
`define LCDHIF_REG_READ_ADDR 4'h4
`define LCDHIF_REG_CTRL 4'h1
`define LCDHIF_REG_START_ADDR 4'h2
`define LCDHIF_REG_START_COM 4'h3
`define LCDHIF_REG_COL_ADDR 4'h5
`define LCDHIF_REG_ROW_ADDR 4'h6
`define LCDHIF_READ_BANK 4'h4

`define LCDHIF_CTRL_WIDTH_BIT 0
`define LCDHIF_CTRL_BURST_BIT 1
`define LCDHIF_CTRL_SHIFT_BIT 2

`define LCDHIF_BANK_RESET 4'h0
`define LCDHIF_SER_BITS_4W 4'h8
`define LCDHIF_SER_BITS_3W 4'h9

`endif

// ---- hdl/lcdhif_pkg.sv ----
// Types shared by the LCD host port.
// Constants live in lcdhif_defines.svh.
package lcdhif_pkg;

  typedef enum logic [3:0] {
    LCDHIF_IDLE = 4'h1,
    LCDHIF_WRITE = 4'h2,
    LCDHIF_READ = 4'h4,
    LCDHIF_DONE = 4'h8
  } lcdhif_phase_t;

  typedef struct packed {
    logic [3:0] reg_addr;
    logic [15:0] data;
    logic to_reg;
  } lcdhif_word_t;

  typedef struct packed {
    logic [2:0] cs_n;
    logic [2:0] rd;
    logic [2:0] wr;
    logic [2:0] sck;
    logic [2:0] sda;
    logic [2:0] sel;
    logic [2:0] rst_n;
    logic [2:0] fm;
    logic [2:0] lp;
  } lcdhif_sync_t;

  typedef struct packed {
    lcdhif_sync_t sync;
    lcdhif_phase_t phase;
    logic [6:0] rst_cnt;
    logic soft_reset;
    logic [15:0] din;
    logic din_sel;
    logic [8:0] shreg;
    logic [3:0] bitcnt;
    logic [3:0] bank;
    logic [3:0] read_addr;
    logic [3:0] read_bank;
    logic [3:0] ctrl;
    logic [6:0] start_addr;
    logic [6:0] start_com;
    logic [6:0] col_addr;
    logic [6:0] row_addr;
    logic [6:0] line_cnt;
    logic dummy_pending;
    logic [15:0] ram_rdata;
    logic burst_half;
    logic [15:0] burst_lo;
    logic [15:0] dout;
    logic dout_en;
    logic ram_we;
    logic [31:0] ram_wdata;
    logic ram_wide;
    logic ram_re;
    logic row_fetch;
    logic [6:0] fetch_row;
  } lcdhif_state_t;

endpackage

// ---- hdl/lcdhif_top.sv ----
// Host-side access logic of a colour STN LCD driver: parallel and serial ports,
// register banks, dummy read, burst writes and the display line counter.
// Assumes all pins are asynchronous to clk; display RAM sits outside.
`timescale 1ns/100ps
`include "lcdhif_defines.svh"

module lcdhif_top #(
  parameter int RESET_CYCLES = `LCDHIF_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic reset_n_pin,
  input wire logic parallel_strap,
  input wire logic bus_style_strap,
  input wire logic serial_variant_strap,
  input wire logic select_polarity_strap,
  input wire logic chip_sel_n,
  input wire logic data_reg_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  input wire logic frame_marker,
  input wire logic line_pulse,
  input wire logic [15:0] ram_rdata,
  output logic ram_we,
  output logic ram_wide,
  output logic [31:0] ram_wdata,
  output logic ram_re,
  output logic [6:0] column_address_reg,
  output logic [6:0] row_address_reg,
  output logic row_fetch,
  output logic [6:0] fetch_row,
  output logic [6:0] start_com,
  output logic shift_ctrl,
  output logic soft_reset
);

  lcdhif_pkg::lcdhif_state_t st;
  lcdhif_pkg::lcdhif_state_t next_st;

  logic rd_now;
  logic wr_now;
  logic sck_rise;
  logic wr_done;
  logic ser_done;
  logic ser_to_reg;
  logic word_valid;
  logic [15:0] word_data;
  logic word_to_reg;
  logic [3:0] ser_bits;
  logic wide;

  always_comb
  begin
    next_st = st;
    // Two-flop synchronisers; bit 2 only holds history for edge finding
    next_st.sync.cs_n = {st.sync.cs_n[1:0], chip_sel_n};
    // Raw pin level: low is an active read strobe in two-strobe style, high is E in enable style
    next_st.sync.rd = {st.sync.rd[1:0], read_strobe_n};
    next_st.sync.wr = {st.sync.wr[1:0], write_strobe_n};
    next_st.sync.sck = {st.sync.sck[1:0], data_in[0]};
    next_st.sync.sda = {st.sync.sda[1:0], data_in[1]};
    next_st.sync.sel = {st.sync.sel[1:0], data_reg_select};
    next_st.sync.rst_n = {st.sync.rst_n[1:0], reset_n_pin};
    next_st.sync.fm = {st.sync.fm[1:0], frame_marker};
    next_st.sync.lp = {st.sync.lp[1:0], line_pulse};

    wide = st.ctrl[`LCDHIF_CTRL_WIDTH_BIT];

    // ------------------------------------------------------------
    // Reset pin qualification
    // ------------------------------------------------------------
    if (!st.sync.rst_n[1])
    begin
      if (st.rst_cnt != 7'(RESET_CYCLES))
        next_st.rst_cnt = st.rst_cnt + 7'h01;
    end
    else
      next_st.rst_cnt = 7'h00;
    // The counter is 7 bits wide, so RESET_CYCLES must stay below 128
    // A short glitch never reaches the counter limit, so it is ignored
    next_st.soft_reset = !st.sync.rst_n[1] && (st.rst_cnt == 7'(RESET_CYCLES));

    // ------------------------------------------------------------
    // Parallel strobes
    // ------------------------------------------------------------
    // In enable style the rd sync carries E; read/write comes from the write pin
    rd_now = parallel_strap && !st.sync.cs_n[1] &&
             (bus_style_strap ? (st.sync.rd[1] && st.sync.wr[1]) : !st.sync.rd[1]);
    wr_done = parallel_strap && !st.sync.cs_n[1] &&
              (bus_style_strap ? (!st.sync.rd[1] && st.sync.rd[2] && !st.sync.wr[1])
                               : (st.sync.wr[1] && !st.sync.wr[2]));
    wr_now = wr_done;
    // Data is held from the strobe active phase because it may change right after the edge
    if (parallel_strap && (bus_style_strap ? st.sync.rd[1] : !st.sync.wr[1]))
    begin
      next_st.din = data_in;
      next_st.din_sel = st.sync.sel[1];
    end

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    // Data and clock pass the same synchroniser depth, so the bit is taken where it stood
    sck_rise = st.sync.sck[1] && !st.sync.sck[2];
    ser_bits = serial_variant_strap ? `LCDHIF_SER_BITS_3W : `LCDHIF_SER_BITS_4W;
    ser_done = 1'b0;
    ser_to_reg = 1'b0;
    if (st.sync.cs_n[1] || parallel_strap)
    begin
      next_st.shreg = 9'h000;
      next_st.bitcnt = 4'h0;
    end
    else if (sck_rise)
    begin
      next_st.shreg = {st.shreg[7:0], st.sync.sda[1]};
      if (st.bitcnt + 4'h1 == ser_bits)
      begin
        ser_done = 1'b1;
        next_st.bitcnt = 4'h0;
        ser_to_reg = serial_variant_strap ? (st.shreg[7] ^ select_polarity_strap)
                                          : st.sync.sel[1];
      end
      else
        next_st.bitcnt = st.bitcnt + 4'h1;
    end

    // Serial words only write; no read path in serial mode
    word_valid = parallel_strap ? wr_now : ser_done;
    word_data = parallel_strap ? st.din : {8'h00, st.shreg[6:0], st.sync.sda[1]};
    word_to_reg = parallel_strap ? st.din_sel : ser_to_reg;

    // ------------------------------------------------------------
    // Register and RAM writes
    // ------------------------------------------------------------
    next_st.ram_we = 1'b0;
    next_st.ram_re = 1'b0;
    next_st.row_fetch = 1'b0;
    if (word_valid)
    begin
      if (word_to_reg)
      begin
        // Low byte only; high nibble is address, low nibble value
        next_st.dummy_pending = 1'b1;
        next_st.burst_half = 1'b0;
        case (word_data[7:4])
          `LCDHIF_REG_BANK_SEL: next_st.bank = word_data[3:0];
          `LCDHIF_REG_READ_ADDR:
          begin
            if (st.bank == `LCDHIF_READ_BANK)
              next_st.read_addr = word_data[3:0];
          end
          `LCDHIF_REG_CTRL: next_st.ctrl = word_data[3:0];
          `LCDHIF_REG_START_ADDR: next_st.start_addr = {st.start_addr[2:0], word_data[3:0]};
          `LCDHIF_REG_START_COM: next_st.start_com = {st.start_com[2:0], word_data[3:0]};
          `LCDHIF_REG_COL_ADDR: next_st.col_addr = {st.col_addr[2:0], word_data[3:0]};
          `LCDHIF_REG_ROW_ADDR: next_st.row_addr = {st.row_addr[2:0], word_data[3:0]};
          default: next_st.read_bank = word_data[3:0];
        endcase
      end
      else
      begin
        next_st.dummy_pending = 1'b1;
        if (st.ctrl[`LCDHIF_CTRL_BURST_BIT] && wide && !st.burst_half)
        begin
          next_st.burst_lo = word_data;
          next_st.burst_half = 1'b1;
        end
        else
        begin
          // Burst pairs two halves into one 32-bit RAM write, low half first
          next_st.ram_we = 1'b1;
          next_st.ram_wide = st.burst_half;
          next_st.ram_wdata = st.burst_half ? {word_data, st.burst_lo}
                                            : {16'h0000, wide ? word_data : {8'h00, word_data[7:0]}};
          next_st.burst_half = 1'b0;
        end
      end
    end

    // ------------------------------------------------------------
    // Read phase
    // ------------------------------------------------------------
    // One read per strobe: the strobe must drop before the next read starts
    case (st.phase)
      lcdhif_pkg::LCDHIF_IDLE:
      begin
        if (rd_now)
        begin
          next_st.phase = lcdhif_pkg::LCDHIF_READ;
          next_st.dout_en = 1'b1;
          if (st.sync.sel[1])
            next_st.dout = {12'hfff, st.read_addr};
          else
          begin
            // First read after address set or write shows stale latch data
            next_st.dout = wide ? st.ram_rdata : {8'h00, st.ram_rdata[7:0]};
            next_st.ram_re = 1'b1;
            next_st.dummy_pending = 1'b0;
          end
        end
      end
      lcdhif_pkg::LCDHIF_READ:
      begin
        if (!rd_now)
        begin
          next_st.phase = lcdhif_pkg::LCDHIF_IDLE;
          next_st.dout_en = 1'b0;
        end
      end
      default: next_st.phase = lcdhif_pkg::LCDHIF_IDLE;
    endcase
    if (st.ram_re)
      next_st.ram_rdata = ram_rdata;

    // ------------------------------------------------------------
    // Display line counter
    // ------------------------------------------------------------
    // Frame marker is a level; the preload holds for as long as it stays high
    if (st.sync.fm[1])
      next_st.line_cnt = st.start_addr;
    else if (!st.sync.lp[1] && st.sync.lp[2])
      next_st.line_cnt = st.line_cnt + 7'h01;
    if (st.sync.lp[1] && !st.sync.lp[2])
    begin
      next_st.row_fetch = 1'b1;
      next_st.fetch_row = st.line_cnt;
    end

    // ------------------------------------------------------------
    // Soft reset from the device pin
    // ------------------------------------------------------------
    // Bus set-up is cleared; display addresses are left alone
    if (st.soft_reset)
    begin
      next_st.bank = `LCDHIF_BANK_RESET;
      next_st.ctrl = 4'h0;
      next_st.dummy_pending = 1'b1;
      next_st.burst_half = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
      st.phase <= lcdhif_pkg::LCDHIF_IDLE;
      st.sync.cs_n <= 3'h7;
      st.sync.rst_n <= 3'h7;
      // Idle write strobe level, so no false rising edge follows reset
      st.sync.wr <= 3'h7;
      st.dummy_pending <= 1'b1;
    end
    else if (clk_en)
      st <= next_st;
  end

  // ------------------------------------------------------------
  // Outputs, all straight from state flops
  // ------------------------------------------------------------
  assign data_out = st.dout;
  assign data_oe = {16{st.dout_en}};
  assign ram_we = st.ram_we;
  assign ram_wide = st.ram_wide;
  assign ram_wdata = st.ram_wdata;
  assign ram_re = st.ram_re;
  assign column_address_reg = st.col_addr;
  assign row_address_reg = st.row_addr;
  assign row_fetch = st.row_fetch;
  assign fetch_row = st.fetch_row;
  assign start_com = st.start_com;
  assign shift_ctrl = st.ctrl[`LCDHIF_CTRL_SHIFT_BIT];
  assign soft_reset = st.soft_reset;

endmodule

// ---- bench/lcdhif_chk_sva.sv ----
// Checker for the LCD host port, watching lcdhif_top pins only.
// Assumes clk_en stays high.
`timescale 1ns/100ps
module lcdhif_chk #(
  parameter int RESET_CYCLES = 100
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_n_pin,
  input wire logic parallel_strap,
  input wire logic bus_style_strap,
  input wire logic chip_sel_n,
  input wire logic data_reg_select,
  input wire logic read_strobe_n,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic line_pulse,
  input wire logic ram_we,
  input wire logic soft_reset,
  input wire logic row_fetch
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----
  // Helper: consecutive low cycles of the reset pin
  // ----
  int low_cnt;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      low_cnt <= 0;
    else if (reset_n_pin)
      low_cnt <= 0;
    else if (low_cnt < 1000)
      low_cnt <= low_cnt + 1;
  end
  sequence s_rd_held;
    (parallel_strap && !bus_style_strap && !chip_sel_n && !read_strobe_n)[*5];
  endsequence
  sequence s_lp_rise;
    !line_pulse[*4] ##1 line_pulse;
  endsequence
  property p_oe_par;
    data_oe != 16'h0000 |-> parallel_strap;
  endproperty
  property p_reg_hi;
    data_reg_select[*5] ##0 data_oe != 16'h0000 |-> data_out[15:4] == 12'hfff;
  endproperty
  property p_oe_on;
    s_rd_held |-> data_oe == 16'hffff;
  endproperty
  property p_oe_off;
    (parallel_strap && !bus_style_strap && read_strobe_n)[*6] |-> data_oe == 16'h0000;
  endproperty
  property p_cs_quiet;
    chip_sel_n[*6] |-> !ram_we;
  endproperty
  property p_we_cause;
    ram_we |-> $past(chip_sel_n, 4) == 1'b0;
  endproperty
  property p_we_pulse;
    ram_we |=> !ram_we;
  endproperty
  property p_fetch;
    s_lp_rise |-> ##[1:5] row_fetch;
  endproperty
  property p_soft;
    $rose(soft_reset) |-> low_cnt >= RESET_CYCLES;
  endproperty
  a_oe_par: assert property (p_oe_par)
    else $error("bus driven in serial mode");
  a_reg_hi: assert property (p_reg_hi)
    else $error("register read upper lines not high");
  a_oe_on: assert property (p_oe_on)
    else $error("read not driven");
  a_oe_off: assert property (p_oe_off)
    else $error("bus driven without read");
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("write while deselected");
  a_we_cause: assert property (p_we_cause)
    else $error("write without select");
  a_we_pulse: assert property (p_we_pulse)
    else $error("write pulse too long");
  a_fetch: assert property (p_fetch)
    else $error("no row fetch on line pulse");
  a_soft: assert property (p_soft)
    else $error("soft reset too early");
endmodule
bind lcdhif_top lcdhif_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.clk(clk), .reset(reset),
  .reset_n_pin(reset_n_pin), .parallel_strap(parallel_strap), .bus_style_strap(bus_style_strap),
  .chip_sel_n(chip_sel_n), .data_reg_select(data_reg_select), .read_strobe_n(read_strobe_n),
  .data_out(data_out), .data_oe(data_oe), .line_pulse(line_pulse), .ram_we(ram_we),
  .soft_reset(soft_reset), .row_fetch(row_fetch));

// ---- bench/lcdhif_host.sv ----
// Host model: drives the parallel and serial pins.
// Assumes tasks are called just after a falling clock edge.
`timescale 1ns/100ps
module lcdhif_host (
  input wire logic clk,
  input wire logic style,
  input wire logic [15:0] q,
  input wire logic [15:0] q_oe,
  output logic cs_n,
  output logic rs,
  output logic rd_n,
  output logic wr_n,
  output logic [15:0] dq
);
  logic cs_lvl;
  initial
  begin
    cs_lvl = 1'b0;
    cs_n = 1'b1;
    rs = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dq = 16'h0000;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pw(input logic r, input logic [15:0] d);
    cs_n = cs_lvl;
    rs = r;
    dq = d;
    wr_n = 1'b0;
    rd_n = 1'b1;
    gap(4);
    if (style)
      rd_n = 1'b0;
    else
      wr_n = 1'b1;
    gap(4);
    wr_n = 1'b1;
    cs_n = 1'b1;
    // Released bus shows garbage, not the old word
    dq = ~d;
    gap(4);
  endtask
  task automatic pr(input logic r, output logic [31:0] v);
    cs_n = 1'b0;
    rs = r;
    wr_n = 1'b1;
    rd_n = style;
    gap(5);
    v = {q_oe, q};
    rd_n = ~style;
    cs_n = 1'b1;
    gap(4);
  endtask
  task automatic sw(input int n, input logic [15:0] w, input logic r);
    // One assignment per time step; the next bit moves as the clock falls
    dq = {{11{1'bz}}, 3'h0, w[n - 1], 1'b0};
    rs = r;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      gap(4);
      dq[0] = 1'b1;
      gap(4);
      dq[1:0] = {(i > 0) ? w[i - 1] : ~w[0], 1'b0};
    end
    gap(4);
    cs_n = 1'b1;
    gap(4);
  endtask
endmodule

// ---- bench/lcdhif_top_tb.sv ----
// Self-checking bench for the LCD host port.
// Assumes lcdhif_host drives the pins; RAM is mirrored here.
`timescale 1ns/100ps
module lcdhif_top_tb;
  localparam int RST = 10;
  logic clk, reset, rst_n_pin, par, sty, var3, pol, fm, lp, cs_n, rs, rd_n, wr_n;
  logic ram_we, ram_re, ram_wide, row_fetch, shift_ctrl, soft_reset;
  logic [15:0] dq, data_out, data_oe;
  logic [15:0] ram_q = 16'h0000;
  logic [31:0] ram_wdata, last_w, v;
  logic [6:0] fetch_row, col, row, scom;
  int re_cnt = 0;
  int num_errors = 0;
  int checks_done = 0;
  int we_cnt = 0;
  lcdhif_host u_host (.clk(clk), .style(sty), .q(data_out), .q_oe(data_oe), .cs_n(cs_n), .rs(rs),
    .rd_n(rd_n), .wr_n(wr_n), .dq(dq));
  lcdhif_top #(.RESET_CYCLES(RST)) dut (.clk(clk), .reset(reset), .clk_en(1'b1), .reset_n_pin(rst_n_pin),
    .parallel_strap(par), .bus_style_strap(sty), .serial_variant_strap(var3), .select_polarity_strap(pol),
    .chip_sel_n(cs_n), .data_reg_select(rs), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(dq),
    .data_out(data_out), .data_oe(data_oe), .frame_marker(fm), .line_pulse(lp), .ram_rdata(ram_q),
    .ram_we(ram_we), .ram_wide(ram_wide), .ram_wdata(ram_wdata), .ram_re(ram_re), .column_address_reg(col),
    .row_address_reg(row), .row_fetch(row_fetch), .fetch_row(fetch_row), .start_com(scom), .shift_ctrl(shift_ctrl),
    .soft_reset(soft_reset));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (ram_re)
      re_cnt <= re_cnt + 1;
    if (ram_we)
    begin
      ram_q <= ram_wdata[15:0];
      we_cnt <= we_cnt + 1;
      last_w <= ram_wdata;
    end
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    gap(30000);
    num_errors++;
    $display("[FAIL] watchdog expected end seen hang");
    summarize();
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    {reset, rst_n_pin, par, sty, var3, pol, fm, lp} = 8'he0;
    gap(2);
    reset = 1'b0;
    gap(4);
    chk("oe idle", 32'(data_oe), 32'h0);
    u_host.pw(1'b1, 16'h0015);
    chk("shift", 32'(shift_ctrl), 32'h1);
    u_host.pw(1'b0, 16'h1234);
    chk("we", 32'(we_cnt), 32'h1);
    chk("wdata", 32'(last_w[15:0]), 32'h1234);
    u_host.pr(1'b0, v);
    u_host.pr(1'b0, v);
    chk("ram rd", v, 32'hffff1234);
    chk("ram re", 32'(re_cnt), 32'h2);
    u_host.pw(1'b1, 16'h00f4);
    u_host.pw(1'b1, 16'h004a);
    u_host.pw(1'b1, 16'h00f0);
    u_host.pr(1'b1, v);
    chk("reg rd", v, 32'hfffffffa);
    u_host.pw(1'b1, 16'h0053);
    u_host.pw(1'b1, 16'h0054);
    u_host.pw(1'b1, 16'h0062);
    u_host.pw(1'b1, 16'h0035);
    u_host.pw(1'b1, 16'h0021);
    u_host.pw(1'b1, 16'h0022);
    chk("col addr", 32'(col), 32'h34);
    chk("row addr", 32'(row), 32'h2);
    chk("start com", 32'(scom), 32'h5);
    $display("test parallel done");
    u_host.pw(1'b1, 16'h0017);
    u_host.pw(1'b0, 16'h1111);
    chk("half", 32'(we_cnt), 32'h1);
    u_host.pw(1'b0, 16'h2222);
    chk("burst", last_w, 32'h22221111);
    chk("wide", 32'(ram_wide), 32'h1);
    u_host.pw(1'b1, 16'h0015);
    u_host.cs_lvl = 1'b1;
    u_host.pw(1'b0, 16'h0f0f);
    u_host.cs_lvl = 1'b0;
    chk("deselected", 32'(we_cnt), 32'h2);
    sty = 1'b1;
    u_host.pw(1'b0, 16'h0055);
    chk("e wr", 32'(last_w[15:0]), 32'h0055);
    u_host.pr(1'b1, v);
    chk("e rd", v, 32'hfffffffa);
    $display("test burst and style done");
    {par, sty} = 2'h0;
    u_host.sw(16, 16'h1410, 1'b1);
    chk("4w two", 32'(shift_ctrl), 32'h0);
    u_host.sw(8, 16'h00a5, 1'b0);
    chk("4w ram", 32'(last_w[7:0]), 32'h00a5);
    u_host.sw(3, 16'h0007, 1'b1);
    u_host.sw(8, 16'h0014, 1'b1);
    chk("4w cs", 32'(shift_ctrl), 32'h1);
    u_host.pr(1'b1, v);
    chk("ser rd", 32'(v[31:16]), 32'h0);
    {var3, pol} = 2'h3;
    u_host.sw(9, 16'h0010, 1'b0);
    chk("3w pol1", 32'(shift_ctrl), 32'h0);
    pol = 1'b0;
    u_host.sw(9, 16'h0114, 1'b0);
    chk("3w pol0", 32'(shift_ctrl), 32'h1);
    u_host.sw(9, 16'h003c, 1'b0);
    chk("3w ram", 32'(last_w[7:0]), 32'h003c);
    $display("test serial done");
    fm = 1'b1;
    gap(6);
    fm = 1'b0;
    repeat (2)
    begin
      gap(6);
      lp = 1'b1;
      gap(6);
      lp = 1'b0;
    end
    gap(6);
    chk("row", 32'(fetch_row), 32'h13);
    rst_n_pin = 1'b0;
    gap(RST + 8);
    chk("soft", 32'(soft_reset), 32'h1);
    rst_n_pin = 1'b1;
    gap(8);
    chk("ctrl clr", 32'(shift_ctrl), 32'h0);
    $display("test display and reset done");
    summarize();
  end
endmodule
